// ===== touch_qual_defines.svh
// Purpose: Offsets, field positions and reset values of the touch qualifier.
// Assumes: Register port is eight bits wide with an eight-bit offset.
// Notes:   Definitions only.
`ifndef TOUCH_QUAL_DEFINES_SVH
`define TOUCH_QUAL_DEFINES_SVH

`define RPT_EN_ADDR    8'h28
`define MT_CFG_ADDR    8'h2a
`define PAT_CFG_ADDR   8'h2b

`define RPT_EN_RESET   8'hff
`define MT_CFG_RESET   8'h80
`define PAT_CFG_RESET  8'h00

`define MT_CFG_MASK    8'h8c
`define PAT_CFG_MASK   8'h8f

`define MT_BLK_EN_BIT  7
`define MT_LIMIT_LSB   2
`define PAT_EN_BIT     7
`define PAT_TH_LSB     2
`define PAT_MATCH_BIT  1
`define PAT_ALERT_BIT  0

`endif

// ===== touch_qual_pkg.sv
// Purpose: Types shared by the touch qualifier modules.
// Assumes: Nothing beyond the defines header.
// Notes:   Reporting mode of the qualifier and the fraction code.
package touch_qual_pkg;

   typedef enum logic [1:0] {
      MODE_FREE,
      MODE_LIMIT,
      MODE_BLOCKED
   } report_mode_t;

   typedef enum logic [1:0] {
      FRAC_EIGHTH,
      FRAC_QUARTER,
      FRAC_THREE_EIGHTHS,
      FRAC_FULL
   } frac_t;

endpackage : touch_qual_pkg

// ===== repeat_timer.sv
// Purpose: Per-input repeat interval counters for held touches.
// Assumes: Period is given in device clock cycles.
// Notes:   A period of zero or one fires every cycle.
`timescale 1ns/1ps
`default_nettype none

module repeat_timer (
   input  wire logic        mclk_in,      // Device clock
   input  wire logic        srst_in,      // Synchronous reset
   input  wire logic [7:0]  held_in,      // Reported touches
   input  wire logic [7:0]  rpt_en_in,    // Repeat enable per input
   input  wire logic [15:0] period_in,    // Repeat interval in cycles
   output logic      [7:0]  fire_out      // One-cycle repeat pulses
);

   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_chan
         logic [15:0] cnt;
         wire         run     = held_in[i] && rpt_en_in[i];
         wire  [15:0] cnt_inc = cnt + 16'h0001;
         wire         due     = run && (cnt_inc >= period_in);

         always_ff @(posedge mclk_in) begin
            if (srst_in || !run || due) begin
               cnt <= 16'h0000;
            end else begin
               cnt <= cnt_inc;
            end
         end

         always_ff @(posedge mclk_in) begin
            if (srst_in) begin
               fire_out[i] <= 1'b0;
            end else begin
               fire_out[i] <= due;
            end
         end

         a_fire_needs_hold : assert property (
            @(posedge mclk_in) disable iff (srst_in)
            fire_out[i] |-> $past(held_in[i]) && $past(rpt_en_in[i]))
            else $error("Repeat pulse without a held, repeat-enabled input");
      end
   endgenerate

endmodule : repeat_timer

`default_nettype wire

// ===== pattern_detect.sv
// Purpose: Pattern detection over one sensing cycle's input states.
// Assumes: Delta and thresholds are eight-bit unsigned per input.
// Notes:   Result is registered on the sensing-cycle strobe.
`timescale 1ns/1ps
`default_nettype none

module pattern_detect
   import touch_qual_pkg::*;
(
   input  wire logic        mclk_in,        // Device clock
   input  wire logic        srst_in,        // Synchronous reset
   input  wire logic        sample_in,      // End of sensing cycle
   input  wire logic        enable_in,      // Pattern detection on
   input  wire logic        match_sel_in,   // 1: exact set, 0: count
   input  wire frac_t       frac_in,        // Threshold fraction
   input  wire logic [7:0]  mask_in,        // Pattern register body
   input  wire logic [63:0] delta_in,       // Delta count per input
   input  wire logic [63:0] act_thr_in,     // Active threshold per input
   input  wire logic [7:0]  sby_thr_in,     // Standby threshold
   input  wire logic [7:0]  sby_sel_in,     // Input sensed in standby
   input  wire logic [7:0]  noise_in,       // Noise flag per input
   output logic             hit_out         // Pattern condition present
);

   wire [7:0]  qual;
   wire [35:0] q_cnt;
   wire [35:0] m_cnt;

   assign q_cnt[3:0] = 4'h0;
   assign m_cnt[3:0] = 4'h0;

   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_chan
         wire [7:0]  thr = sby_sel_in[i] ? sby_thr_in : act_thr_in[8*i +: 8];
         wire [10:0] lhs = {delta_in[8*i +: 8], 3'b000};
         wire [10:0] rhs = (frac_in == FRAC_FULL)    ? {thr, 3'b000} :
                           (frac_in == FRAC_QUARTER) ? {2'b00, thr, 1'b0} :
                           (frac_in == FRAC_EIGHTH)  ? {3'b000, thr} :
                           {3'b000, thr} + {2'b00, thr, 1'b0};
         assign qual[i] = (lhs > rhs) || noise_in[i];
         assign q_cnt[4*i+4 +: 4] = q_cnt[4*i +: 4] + {3'b000, qual[i]};
         assign m_cnt[4*i+4 +: 4] = m_cnt[4*i +: 4] + {3'b000, mask_in[i]};
      end
   endgenerate

   wire match_hit = ((qual & mask_in) == mask_in);
   wire count_hit = (q_cnt[35:32] >= m_cnt[35:32]);
   // Empty pattern would match trivially, so it never flags
   wire hit_now   = enable_in && (mask_in != 8'h00) &&
                    (match_sel_in ? match_hit : count_hit);

   always_ff @(posedge mclk_in) begin
      if (srst_in || !enable_in) begin
         hit_out <= 1'b0;
      end else if (sample_in) begin
         hit_out <= hit_now;
      end
   end

   a_match_mode : assert property (
      @(posedge mclk_in) disable iff (srst_in)
      sample_in && enable_in && match_sel_in && mask_in != 8'h00 && match_hit
      |=> hit_out)
      else $error("Exact pattern present but not flagged");

   a_count_mode : assert property (
      @(posedge mclk_in) disable iff (srst_in)
      sample_in && enable_in && !match_sel_in && mask_in != 8'h00
      |=> hit_out == $past(count_hit))
      else $error("Count mode result wrong");

   a_disabled_quiet : assert property (
      @(posedge mclk_in) disable iff (srst_in)
      !enable_in |=> !hit_out)
      else $error("Pattern flagged while detection disabled");

endmodule : pattern_detect

`default_nettype wire

// ===== touch_qual.sv
// Purpose: Repeat, multi-touch blocking and pattern qualification of touches.
// Assumes: Sensing front end, thresholds and host bus sit outside.
// Notes:   Touch report updates two edges after the sensing-cycle strobe.
`timescale 1ns/1ps
`default_nettype none
`include "touch_qual_defines.svh"

module touch_qual
   import touch_qual_pkg::*;
(
   input  wire logic        mclk_in,          // Device clock, 125 MHz
   input  wire logic        srst_in,          // Synchronous reset, high
   input  wire logic [7:0]  reg_addr_in,      // Register offset
   input  wire logic [7:0]  reg_wdata_in,     // Register write data
   input  wire logic        reg_wr_in,        // Register write strobe
   output logic      [7:0]  reg_rdata_out,    // Registered read data
   input  wire logic        cycle_done_in,    // End of sensing cycle pulse
   input  wire logic [7:0]  touch_in,         // Above touch threshold
   input  wire logic [7:0]  noise_in,         // Noise flags
   input  wire logic [63:0] delta_in,         // Delta counts, input k at 8k
   input  wire logic [63:0] act_thr_in,       // Active thresholds
   input  wire logic [7:0]  sby_thr_in,       // Standby threshold
   input  wire logic [7:0]  sby_sel_in,       // Inputs sensed in standby
   input  wire logic [7:0]  pattern_mask_in,  // Pattern register body
   input  wire logic        release_int_select_in, // Release interrupts on
   input  wire logic [15:0] repeat_period_in, // Repeat interval, cycles
   input  wire logic        int_clear_in,     // Host writes zero to main flag
   output logic      [7:0]  touch_status_out, // Reported touches
   output logic             multi_touch_status_flag_out, // Too many touches
   output logic             pattern_event_flag_out,      // Pattern event
   output logic             int_flag_out,     // Main interrupt flag
   output logic             alert_n_out       // Alert pin, active low
);

   logic [7:0]   repeat_enable_per_input;
   logic [7:0]   multi_touch_block_config;
   logic [7:0]   touch_pattern_config;
   logic [7:0]   touch_q;
   logic         apply_q;
   logic [7:0]   accepted;
   report_mode_t mode;
   wire          pat_cond;
   wire  [7:0]   rpt_fire;

   // Register decode
   wire hit_rpt = (reg_addr_in == `RPT_EN_ADDR);
   wire hit_mt  = (reg_addr_in == `MT_CFG_ADDR);
   wire hit_pat = (reg_addr_in == `PAT_CFG_ADDR);
   wire [7:0] rd_mux = hit_rpt ? repeat_enable_per_input :
                       hit_mt  ? multi_touch_block_config :
                       hit_pat ? touch_pattern_config : 8'h00;

   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         repeat_enable_per_input  <= `RPT_EN_RESET;
         multi_touch_block_config <= `MT_CFG_RESET;
         touch_pattern_config     <= `PAT_CFG_RESET;
      end else if (reg_wr_in) begin
         if (hit_rpt) begin
            repeat_enable_per_input <= reg_wdata_in;
         end else if (hit_mt) begin
            multi_touch_block_config <= reg_wdata_in & `MT_CFG_MASK;
         end else if (hit_pat) begin
            touch_pattern_config <= reg_wdata_in & `PAT_CFG_MASK;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         reg_rdata_out <= 8'h00;
      end else begin
         reg_rdata_out <= rd_mux;
      end
   end

   // Field views
   wire       multi_touch_block_enable = multi_touch_block_config[`MT_BLK_EN_BIT];
   wire [1:0] simultaneous_touch_limit = multi_touch_block_config[`MT_LIMIT_LSB +: 2];
   wire [3:0] limit = {2'b00, simultaneous_touch_limit} + 4'h1;
   wire       pattern_detect_enable = touch_pattern_config[`PAT_EN_BIT];
   wire [1:0] pattern_threshold_fraction = touch_pattern_config[`PAT_TH_LSB +: 2];
   wire       pattern_match_select = touch_pattern_config[`PAT_MATCH_BIT];
   wire       pattern_alert_enable = touch_pattern_config[`PAT_ALERT_BIT];

   pattern_detect u_pattern (
      .mclk_in      (mclk_in),
      .srst_in      (srst_in),
      .sample_in    (cycle_done_in),
      .enable_in    (pattern_detect_enable),
      .match_sel_in (pattern_match_select),
      .frac_in      (frac_t'(pattern_threshold_fraction)),
      .mask_in      (pattern_mask_in),
      .delta_in     (delta_in),
      .act_thr_in   (act_thr_in),
      .sby_thr_in   (sby_thr_in),
      .sby_sel_in   (sby_sel_in),
      .noise_in     (noise_in),
      .hit_out      (pat_cond)
   );

   // Snapshot touches with the pattern sample so both see one cycle
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         touch_q <= 8'h00;
         apply_q <= 1'b0;
      end else begin
         apply_q <= cycle_done_in;
         if (cycle_done_in) begin
            touch_q <= touch_in;
         end
      end
   end

   // First-N scan in sensing order, input 0 first
   wire [35:0] run_cnt;
   wire [7:0]  pick;
   assign run_cnt[3:0] = 4'h0;

   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_scan
         assign pick[i] = touch_q[i] && (run_cnt[4*i +: 4] < limit);
         assign run_cnt[4*i+4 +: 4] = run_cnt[4*i +: 4] + {3'b000, touch_q[i]};
      end
   endgenerate

   wire [3:0] touch_count = run_cnt[35:32];
   // Accepted set stays until any member releases
   wire keep_set = (accepted != 8'h00) && ((accepted & touch_q) == accepted);

   wire report_mode_t next_mode = pat_cond ? MODE_BLOCKED :
                                  multi_touch_block_enable ? MODE_LIMIT : MODE_FREE;
   wire [7:0] next_accepted = keep_set ? accepted : pick;
   wire [7:0] next_status   = (next_mode == MODE_BLOCKED) ? 8'h00 :
                              (next_mode == MODE_FREE) ? touch_q :
                              next_accepted;
   wire       over_limit = (next_mode == MODE_LIMIT) && (touch_count > limit);

   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         mode     <= MODE_FREE;
         accepted <= 8'h00;
      end else if (apply_q) begin
         mode     <= next_mode;
         accepted <= (next_mode == MODE_LIMIT) ? next_accepted : 8'h00;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         touch_status_out            <= 8'h00;
         multi_touch_status_flag_out <= 1'b0;
      end else if (apply_q) begin
         touch_status_out            <= next_status;
         multi_touch_status_flag_out <= over_limit;
      end
   end

   repeat_timer u_repeat (
      .mclk_in   (mclk_in),
      .srst_in   (srst_in),
      .held_in   (touch_status_out),
      .rpt_en_in (repeat_enable_per_input),
      .period_in (repeat_period_in),
      .fire_out  (rpt_fire)
   );

   // Interrupt events
   wire [7:0] press_ev   = next_status & ~touch_status_out;
   wire [7:0] release_ev = touch_status_out & ~next_status;
   wire touch_event = apply_q && ((press_ev != 8'h00) ||
                      (release_int_select_in && (release_ev != 8'h00)));
   wire repeat_event = (rpt_fire & repeat_enable_per_input) != 8'h00;
   wire pat_new  = apply_q && pat_cond && (mode != MODE_BLOCKED);
   wire pat_set  = apply_q && pat_cond;
   // Condition still present keeps the flag; the set wins over a clear
   wire next_pat_flag = pat_set || (pattern_event_flag_out &&
                        !(int_clear_in && !pat_cond));
   wire int_set  = touch_event || repeat_event ||
                   (pat_new && pattern_alert_enable);
   wire next_int_flag = int_set || (int_flag_out && !int_clear_in);

   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         pattern_event_flag_out <= 1'b0;
         int_flag_out           <= 1'b0;
         alert_n_out            <= 1'b1;
      end else begin
         pattern_event_flag_out <= next_pat_flag;
         int_flag_out           <= next_int_flag;
         alert_n_out            <= !next_int_flag;
      end
   end

   // Checks
   a_free_pass : assert property (
      @(posedge mclk_in) disable iff (srst_in)
      apply_q && !multi_touch_block_enable && !pat_cond
      |=> touch_status_out == $past(touch_q))
      else $error("Touches altered while blocking is off");

   a_scan_order : assert property (
      @(posedge mclk_in) disable iff (srst_in)
      apply_q && multi_touch_block_enable && !pat_cond && !keep_set
      |=> touch_status_out == $past(pick))
      else $error("Reselection not in sensing order");

   a_keep_set : assert property (
      @(posedge mclk_in) disable iff (srst_in)
      apply_q && multi_touch_block_enable && !pat_cond && keep_set
      |=> touch_status_out == $past(accepted))
      else $error("Accepted set dropped while all held");

   a_limit_map : assert property (
      @(posedge mclk_in) disable iff (srst_in)
      simultaneous_touch_limit == 2'b11 |-> limit == 4'h4)
      else $error("Limit code three does not give four touches");

   a_multi_flag : assert property (
      @(posedge mclk_in) disable iff (srst_in)
      apply_q && multi_touch_block_enable && !pat_cond && touch_count > limit
      |=> multi_touch_status_flag_out)
      else $error("Too many touches not flagged");

   a_pat_blocks : assert property (
      @(posedge mclk_in) disable iff (srst_in)
      apply_q && pat_cond |=> touch_status_out == 8'h00 ##0 mode == MODE_BLOCKED)
      else $error("Touches reported during pattern event");

   a_pat_hold : assert property (
      @(posedge mclk_in) disable iff (srst_in)
      pattern_event_flag_out && pat_cond |=> pattern_event_flag_out)
      else $error("Pattern flag cleared while condition present");

   a_pat_alert : assert property (
      @(posedge mclk_in) disable iff (srst_in)
      pat_new && pattern_alert_enable |=> !alert_n_out && pattern_event_flag_out)
      else $error("Enabled pattern event did not assert alert");

   a_release_int : assert property (
      @(posedge mclk_in) disable iff (srst_in)
      apply_q && release_int_select_in && release_ev != 8'h00 |=> !alert_n_out)
      else $error("Release interrupt missing");

   a_no_rpt_tick : assert property (
      @(posedge mclk_in) disable iff (srst_in)
      !apply_q && !int_flag_out && !pat_new && (rpt_fire & repeat_enable_per_input) == 8'h00
      |=> !int_flag_out)
      else $error("Interrupt raised with no event");

   a_alert_mirror : assert property (
      @(posedge mclk_in) disable iff (srst_in)
      alert_n_out != int_flag_out)
      else $error("Alert pin disagrees with interrupt flag");

   a_int_clear : assert property (
      @(posedge mclk_in) disable iff (srst_in)
      int_clear_in && !int_set |=> !int_flag_out)
      else $error("Interrupt flag survived a host clear");

   a_pat_clear : assert property (
      @(posedge mclk_in) disable iff (srst_in)
      int_clear_in && !pat_cond |=> !pattern_event_flag_out)
      else $error("Pattern flag kept after condition cleared");

   a_press_int : assert property (
      @(posedge mclk_in) disable iff (srst_in)
      apply_q && press_ev != 8'h00 |=> int_flag_out)
      else $error("New touch raised no interrupt");

   a_repeat_int : assert property (
      @(posedge mclk_in) disable iff (srst_in)
      repeat_event |=> int_flag_out)
      else $error("Repeat pulse raised no interrupt");

   a_rpt_readback : assert property (
      @(posedge mclk_in) disable iff (srst_in)
      hit_rpt |=> reg_rdata_out == $past(repeat_enable_per_input))
      else $error("Repeat enable register read back wrong");

   a_pat_restore : assert property (
      @(posedge mclk_in) disable iff (srst_in)
      apply_q && !pat_cond |=> mode != MODE_BLOCKED)
      else $error("Touches still blocked after pattern condition left");

   a_free_no_multi : assert property (
      @(posedge mclk_in) disable iff (srst_in)
      apply_q && !multi_touch_block_enable |=> !multi_touch_status_flag_out)
      else $error("Multi-touch flag set while blocking is off");

endmodule : touch_qual

`default_nettype wire

// ===== sense_front.sv
// Purpose: Sensing front end model that delivers one sensing cycle on request.
// Assumes: The bench asks for a cycle with go_in high for one clock.
// Notes:   Delta is 8'h40 on hot inputs and zero elsewhere.
`timescale 1ns/1ps
`default_nettype none

module sense_front (
   input  wire logic        mclk_in,      // Device clock
   input  wire logic        go_in,        // Start one sensing cycle
   input  wire logic [7:0]  touch_set_in, // Touches to present
   input  wire logic [7:0]  hot_set_in,   // Inputs with large delta
   input  wire logic [7:0]  noise_set_in, // Noise flags to present
   output logic             done_out,     // End of cycle pulse
   output logic      [7:0]  touch_out,    // Touch states
   output logic      [7:0]  noise_out,    // Noise flags
   output logic      [63:0] delta_out     // Delta counts, input k at 8k
);
   initial begin
      done_out = 1'b0;
      touch_out = 8'h00;
      noise_out = 8'h00;
      delta_out = 64'h0;
   end
   // All values change together with the strobe, as one sensing cycle
   always @(posedge mclk_in) begin
      done_out <= go_in;
      if (go_in) begin
         touch_out <= touch_set_in;
         noise_out <= noise_set_in;
         for (int k = 0; k < 8; k++) delta_out[8*k +: 8] <= hot_set_in[k] ? 8'h40 : 8'h00;
      end
   end
endmodule : sense_front
`default_nettype wire

// ===== testbench.sv
// Purpose: Self-checking bench for the touch qualifier.
// Assumes: Active thresholds 8'h50, input 2 at 8'hc0; standby threshold 8'h20.
// Notes:   Repeat period is short so repeats show within a few dozen cycles.
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic             mclk_in = 1'b0;
   logic             srst_in = 1'b1;
   logic [7:0]       addr = 8'h00, wdata = 8'h00, mask = 8'h00;
   logic [7:0]       tset = 8'h00, hset = 8'h00, nset = 8'h00;
   logic [7:0]       sby = 8'h00;
   logic             wr = 1'b0, go = 1'b0, rel_sel = 1'b0, clr_int = 1'b0;
   int               fails = 0, tests_run = 0, cycles = 0;
   wire logic        done, multi, pat, intf, alert_n;
   wire logic [7:0]  rdata, touch, noise, status;
   wire logic [63:0] delta;

   always #4 mclk_in = ~mclk_in;

   sense_front sense_front_inst (.mclk_in(mclk_in), .go_in(go), .touch_set_in(tset),
      .hot_set_in(hset), .noise_set_in(nset), .done_out(done), .touch_out(touch),
      .noise_out(noise), .delta_out(delta));

   touch_qual touch_qual_inst (.mclk_in(mclk_in), .srst_in(srst_in), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rdata_out(rdata), .cycle_done_in(done),
      .touch_in(touch), .noise_in(noise), .delta_in(delta),
      .act_thr_in({{5{8'h50}}, 8'hc0, {2{8'h50}}}), .sby_thr_in(8'h20), .sby_sel_in(sby),
      .pattern_mask_in(mask),
      .release_int_select_in(rel_sel), .repeat_period_in(16'h0004), .int_clear_in(clr_int),
      .touch_status_out(status), .multi_touch_status_flag_out(multi),
      .pattern_event_flag_out(pat), .int_flag_out(intf), .alert_n_out(alert_n));

   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk8

   task automatic chk1(input string what, input logic exp, input logic got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %b, seen %b", what, exp, got);
      end
   endtask : chk1

   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk_in);
      wr <= 1'b0;
   endtask : wreg

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk_in);
      addr <= a;
      repeat (2) @(posedge mclk_in);
      #1 chk8("register", exp, rdata);
   endtask : rchk

   // Result stands from the third edge after the request until the next cycle
   task automatic sense(input logic [7:0] t, input logic [7:0] h, input logic [7:0] n);
      @(posedge mclk_in);
      go <= 1'b1;
      tset <= t;
      hset <= h;
      nset <= n;
      @(posedge mclk_in);
      go <= 1'b0;
      repeat (4) @(posedge mclk_in);
      #1;
   endtask : sense

   task automatic clr();
      @(posedge mclk_in);
      clr_int <= 1'b1;
      @(posedge mclk_in);
      clr_int <= 1'b0;
      #1;
   endtask : clr

   task automatic t_regs();
      rchk(8'h28, 8'hff);
      rchk(8'h2a, 8'h80);
      rchk(8'h2b, 8'h00);
      rchk(8'h29, 8'h00);
      wreg(8'h2a, 8'hff);
      rchk(8'h2a, 8'h8c);
      wreg(8'h2b, 8'hff);
      rchk(8'h2b, 8'h8f);
      wreg(8'h2b, 8'h00);
      $display("test registers done");
   endtask : t_regs

   task automatic t_block();
      for (int c = 0; c < 4; c++) begin
         wreg(8'h2a, 8'h80 | 8'(c << 2));
         sense(8'h00, 8'h00, 8'h00);
         sense(8'hff, 8'h00, 8'h00);
         chk8("limited touches", 8'((9'h002 << c) - 9'h001), status);
         chk1("multi touch flag", 1'b1, multi);
      end
      wreg(8'h2a, 8'h84);
      sense(8'h00, 8'h00, 8'h00);
      sense(8'h0f, 8'h00, 8'h00);
      chk8("first two", 8'h03, status);
      sense(8'h0e, 8'h00, 8'h00);
      chk8("rescan", 8'h06, status);
      sense(8'h07, 8'h00, 8'h00);
      chk8("kept set", 8'h06, status);
      wreg(8'h2a, 8'h00);
      sense(8'hff, 8'h00, 8'h00);
      chk8("no blocking", 8'hff, status);
      chk1("multi touch flag", 1'b0, multi);
      $display("test blocking done");
   endtask : t_block

   task automatic t_int();
      wreg(8'h28, 8'h00);
      sense(8'h00, 8'h00, 8'h00);
      clr();
      sense(8'h01, 8'h00, 8'h00);
      chk1("alert", 1'b0, alert_n);
      clr();
      sense(8'h01, 8'h00, 8'h00);
      repeat (20) @(posedge mclk_in);
      #1 chk1("interrupt flag", 1'b0, intf);
      wreg(8'h28, 8'h01);
      repeat (12) @(posedge mclk_in);
      #1 chk1("interrupt flag", 1'b1, intf);
      wreg(8'h28, 8'h00);
      clr();
      sense(8'h00, 8'h00, 8'h00);
      chk1("interrupt flag", 1'b0, intf);
      @(posedge mclk_in) rel_sel <= 1'b1;
      sense(8'h01, 8'h00, 8'h00);
      clr();
      sense(8'h00, 8'h00, 8'h00);
      chk1("interrupt flag", 1'b1, intf);
      @(posedge mclk_in) rel_sel <= 1'b0;
      $display("test interrupts done");
   endtask : t_int

   task automatic t_pat();
      @(posedge mclk_in) mask <= 8'h03;
      wreg(8'h2b, 8'h82);
      clr();
      sense(8'h04, 8'h03, 8'h00);
      chk1("pattern flag", 1'b1, pat);
      chk1("alert", 1'b1, alert_n);
      chk8("blocked touches", 8'h00, status);
      clr();
      chk1("pattern flag", 1'b1, pat);
      sense(8'h04, 8'h01, 8'h00);
      chk8("restored touches", 8'h04, status);
      clr();
      chk1("pattern flag", 1'b0, pat);
      wreg(8'h2b, 8'h81);
      sense(8'h00, 8'h20, 8'h40);
      chk1("pattern flag", 1'b1, pat);
      chk1("alert", 1'b0, alert_n);
      sense(8'h00, 8'h00, 8'h00);
      clr();
      wreg(8'h2b, 8'h8e);
      sense(8'h00, 8'h03, 8'h00);
      chk1("pattern flag", 1'b0, pat);
      @(posedge mclk_in) sby <= 8'h03;
      sense(8'h00, 8'h03, 8'h00);
      chk1("standby pattern flag", 1'b1, pat);
      sense(8'h00, 8'h00, 8'h00);
      clr();
      chk1("pattern flag", 1'b0, pat);
      @(posedge mclk_in) mask <= 8'h04;
      wreg(8'h2b, 8'h86);
      sense(8'h00, 8'h04, 8'h00);
      chk1("quarter pattern flag", 1'b1, pat);
      wreg(8'h2b, 8'h8a);
      sense(8'h00, 8'h04, 8'h00);
      clr();
      chk1("three eighths pattern flag", 1'b0, pat);
      wreg(8'h2b, 8'h02);
      sense(8'h00, 8'hff, 8'h00);
      chk1("pattern flag", 1'b0, pat);
      $display("test pattern done");
   endtask : t_pat

   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test

   // Whole run needs well under a thousand cycles
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         finish_test();
      end
   end

   initial begin
      repeat (4) @(posedge mclk_in);
      srst_in <= 1'b0;
      t_regs();
      t_block();
      t_int();
      t_pat();
      finish_test();
   end
endmodule : testbench
`default_nettype wire
